// >>> core/quad_pkg.sv
// shared constants for the two-channel quadrature counter
package quad_pkg;
    // register word addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_COUNT0 = 8'h08;
    localparam logic [7:0] ADDR_COUNT1 = 8'h0C;
    localparam logic [7:0] ADDR_SUPPLY = 8'h10;
    localparam logic [7:0] ADDR_CODEWORD = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_STORED0 = 8'h28;
    localparam logic [7:0] ADDR_STORED1 = 8'h2C;
    // channel control fields
    localparam int SIGTYPE_LSB = 0;
    localparam int EVAL_LSB = 4;
    localparam int COMPAT_BIT = 8;
    localparam int CLEAR_BIT = 9;
    // status word bit positions per process-image mode
    localparam int STAT_LATCH_COMPAT = 13;
    localparam int STAT_TOGGLE_COMPAT = 16;
    localparam int STAT_CYCLE_NORMAL = 15;
    localparam int STAT_LATCH_NORMAL = 20;
    // signal types
    localparam logic [2:0] SIG_RS422_ENC = 3'h0;
    localparam logic [2:0] SIG_RS422_PULSE = 3'h1;
    localparam logic [2:0] SIG_TTL_ENC = 3'h2;
    localparam logic [2:0] SIG_TTL_PULSE = 3'h3;
    localparam logic [2:0] SIG_OC_ENC = 3'h4;
    localparam logic [2:0] SIG_OC_PULSE = 3'h5;
    // evaluation settings
    localparam logic [1:0] EVAL_X1 = 2'h0;
    localparam logic [1:0] EVAL_X2 = 2'h1;
    localparam logic [1:0] EVAL_X4 = 2'h2;
    // supply selections
    localparam logic [1:0] SUPPLY_5V = 2'h0;
    localparam logic [1:0] SUPPLY_12V = 2'h1;
    localparam logic [1:0] SUPPLY_24V = 2'h2;
    localparam logic [31:0] CODE_WORD_USER = 32'h72657375;
    // interrupt bits
    localparam int IRQ_WRAP0 = 0;
    localparam int IRQ_WRAP1 = 1;
    localparam int IRQ_SUPPLY_REJ = 2;
    localparam int IRQ_BITS = 3;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h00000020;
endpackage : quad_pkg

// >>> core/quad_sync.sv
// two-flop synchroniser for a bundle of track inputs
`timescale 1ns/1ns
`default_nettype none
module quad_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (reset) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : quad_sync
`default_nettype wire

// >>> core/quad_decode.sv
// edge decoder: turns synchronised A/B into count steps
`timescale 1ns/1ns
`default_nettype none
module quad_decode
    import quad_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic track_a,
    input wire logic track_b,
    input wire logic [2:0] sig_type,
    input wire logic [1:0] eval_mode,
    output logic step,
    output logic step_down
);
    logic prev_a;
    logic prev_b;
    logic pulse_mode;
    logic edge_a;
    logic edge_b;
    logic rise_a;

    assign pulse_mode = (sig_type == SIG_RS422_PULSE) ||
        (sig_type == SIG_TTL_PULSE) || (sig_type == SIG_OC_PULSE);
    assign edge_a = track_a ^ prev_a;
    assign edge_b = track_b ^ prev_b;
    assign rise_a = track_a & ~prev_a;

    // previous levels; an edge is a change against the level one clock earlier
    always_ff @(posedge clock) begin
        if (reset) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            prev_a <= track_a;
            prev_b <= track_b;
        end
    end

    // step and direction, combinational; caller registers the count
    always_comb begin
        step = 1'b0;
        step_down = 1'b0;
        if (pulse_mode) begin
            // direction from the B level: low or open counts up
            step_down = track_b;
            case (eval_mode)
                EVAL_X1: step = rise_a;
                default: step = edge_a; // pulse input has no B edges
            endcase
        end else begin
            case (eval_mode)
                EVAL_X1: step = rise_a;
                EVAL_X2: step = edge_a;
                EVAL_X4: step = edge_a | edge_b;
                default: step = 1'b0;
            endcase
            // A leading B: A edge with A != B, or B edge with A == B
            if (edge_a)
                step_down = (track_a == track_b);
            else
                step_down = (track_a != track_b);
        end
    end
endmodule : quad_decode
`default_nettype wire

// >>> core/quad_counter.sv
// two-channel quadrature counter with register port and interrupt
// Operation
// - per channel selector: RS422, TTL, open collector; encoder or pulse
// - selectors 1, 3, 5 take direction from track B level
// - 1-fold rising A, 2-fold both A edges, 4-fold all A/B edges on encoder, both A edges on pulse
// - 4-fold evaluation after reset
// - supply setting 5, 12 or 24 V, 5 V after reset
// - one supply setting for both channels from channel one
// - supply writes accepted only while code word holds the user value
// - each channel's current count readable as its own value
// - compat mode: set count from host only; reset still allowed
// - compat mode: store and reset count on zero pulse/latch, freeze from gate only
// - compat mode: direction detection kept (counts down as in normal mode), filtering kept
// - status bit placement differs between compat and normal mode
// - encoder counts up when A leads B, down when A lags
// - pulse input counts up with B low, down with B high
`timescale 1ns/1ns
`default_nettype none
module quad_counter
    import quad_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int COUNT_WIDTH = 32
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [CHANNELS-1:0] track_a,
    input wire logic [CHANNELS-1:0] track_b,
    input wire logic [CHANNELS-1:0] latch_in,
    input wire logic [CHANNELS-1:0] gate_in,
    input wire logic [CHANNELS-1:0] set_req,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    output logic [1:0] supply_select,
    output logic irq
);
    // refuse sizes that the register map cannot serve
    if (CHANNELS != 2 || COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin : g_bad
        $error("quad_counter: unsupported parameters");
    end

    logic [31:0] ctrl [CHANNELS];
    logic [COUNT_WIDTH-1:0] count [CHANNELS];
    logic [COUNT_WIDTH-1:0] stored [CHANNELS];
    logic [31:0] set_value;
    logic [31:0] code_word;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_event;
    logic [CHANNELS-1:0] wrap;
    logic [CHANNELS-1:0] step;
    logic [CHANNELS-1:0] step_down;
    logic [CHANNELS-1:0] a_sync;
    logic [CHANNELS-1:0] b_sync;
    logic [CHANNELS-1:0] latch_prev;
    logic [CHANNELS-1:0] latch_seen;
    logic supply_reject;
    logic write_supply;
    logic [31:0] next_read;
    logic [CHANNELS-1:0] updated;
    logic data_toggle;

    // both tracks through a synchroniser before any edge logic
    quad_sync #(.WIDTH(2 * CHANNELS)) track_sync (
        .clock(clock),
        .reset(reset),
        .async_in({track_b, track_a}),
        .sync_out({b_sync, a_sync})
    );

    // host set value shared by the channels
    always_ff @(posedge clock) begin
        if (reset)
            set_value <= '0;
        else if (write_strobe && address == ADDR_STATUS)
            set_value <= write_data;
    end

    // supply write guarded by the code word, channel one only
    assign write_supply = write_strobe && address == ADDR_SUPPLY;
    assign supply_reject = write_supply && code_word != CODE_WORD_USER;
    always_ff @(posedge clock) begin
        if (reset) begin
            supply_select <= SUPPLY_5V;
            code_word <= '0;
        end else begin
            if (write_strobe && address == ADDR_CODEWORD)
                code_word <= write_data;
            if (write_supply && code_word == CODE_WORD_USER &&
                write_data[1:0] <= SUPPLY_24V)
                supply_select <= write_data[1:0];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic compat;
            logic frozen;
            logic latch_rise;
            logic [7:0] ctrl_addr;
            assign ctrl_addr = (ch == 0) ? ADDR_CTRL0 : ADDR_CTRL1;
            assign compat = ctrl[ch][COMPAT_BIT];
            // gate freezes the count only in compat mode
            assign frozen = compat & gate_in[ch];
            assign latch_rise = latch_in[ch] & ~latch_prev[ch];
            // any change of the count marks fresh data for the master
            assign updated[ch] = set_req[ch] | ctrl[ch][CLEAR_BIT] |
                (compat & latch_rise) | (step[ch] & ~frozen);

            quad_decode decoder (
                .clock(clock),
                .reset(reset),
                .track_a(a_sync[ch]),
                .track_b(b_sync[ch]),
                .sig_type(ctrl[ch][SIGTYPE_LSB +: 3]),
                .eval_mode(ctrl[ch][EVAL_LSB +: 2]),
                .step(step[ch]),
                .step_down(step_down[ch])
            );

            // control word; clear bit is self-clearing
            always_ff @(posedge clock) begin
                if (reset)
                    ctrl[ch] <= CTRL_RESET;
                else if (write_strobe && address == ctrl_addr)
                    ctrl[ch] <= {22'h000000, write_data[CLEAR_BIT:0]};
                else
                    ctrl[ch][CLEAR_BIT] <= 1'b0;
            end

            // count: host set, latch reset, then steps; leaves value
            always_ff @(posedge clock) begin
                if (reset) begin
                    count[ch] <= '0;
                    stored[ch] <= '0;
                    latch_prev[ch] <= 1'b0;
                    latch_seen[ch] <= 1'b0;
                    wrap[ch] <= 1'b0;
                end else begin
                    latch_prev[ch] <= latch_in[ch];
                    wrap[ch] <= 1'b0;
                    if (latch_rise) begin
                        stored[ch] <= count[ch];
                        latch_seen[ch] <= 1'b1;
                    end else if (read_strobe && address == ADDR_STATUS) begin
                        latch_seen[ch] <= 1'b0;
                    end
                    if (set_req[ch]) begin
                        count[ch] <= set_value[COUNT_WIDTH-1:0];
                    end else if (ctrl[ch][CLEAR_BIT] ||
                                 (compat && latch_rise)) begin
                        count[ch] <= '0;
                    end else if (step[ch] && !frozen) begin
                        if (step_down[ch] && !compat) begin
                            count[ch] <= count[ch] - 1'b1;
                            wrap[ch] <= (count[ch] == '0);
                        end else if (step_down[ch]) begin
                            // compat mode counts down the same as normal mode
                            count[ch] <= count[ch] - 1'b1;
                            wrap[ch] <= (count[ch] == '0);
                        end else begin
                            count[ch] <= count[ch] + 1'b1;
                            wrap[ch] <= (&count[ch]);
                        end
                    end
                end
            end
        end
    endgenerate

    // sticky events, write one to clear; a new event beats the clear
    assign irq_event = {supply_reject, wrap[1], wrap[0]};
    always_ff @(posedge clock) begin
        if (reset) begin
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end else begin
            if (write_strobe && address == ADDR_IRQ_MASK)
                irq_mask <= write_data[IRQ_BITS-1:0];
            if (write_strobe && address == ADDR_IRQ_STATUS)
                irq_status <= (irq_status & ~write_data[IRQ_BITS-1:0]) |
                    irq_event;
            else
                irq_status <= irq_status | irq_event;
            irq <= |(irq_status & irq_mask);
        end
    end

    // fresh-data toggle; a fast master compares it between reads
    always_ff @(posedge clock) begin
        if (reset)
            data_toggle <= 1'b0;
        else if (|updated)
            data_toggle <= ~data_toggle;
    end

    // status word layout follows the process-image mode of channel one
    function automatic logic [31:0] status_word(input logic compat);
        logic [31:0] w;
        w = '0;
        if (compat) begin
            w[STAT_LATCH_COMPAT] = latch_seen[0];
            w[STAT_TOGGLE_COMPAT] = data_toggle;
        end else begin
            w[STAT_LATCH_NORMAL] = latch_seen[0];
            w[STAT_CYCLE_NORMAL] = data_toggle;
        end
        w[1:0] = latch_seen;
        return w;
    endfunction

    // read mux, data valid the cycle after the strobe
    always_comb begin
        next_read = '0;
        case (address)
            ADDR_CTRL0: next_read = ctrl[0];
            ADDR_CTRL1: next_read = ctrl[1];
            ADDR_COUNT0: next_read = 32'(count[0]);
            ADDR_COUNT1: next_read = 32'(count[1]);
            ADDR_SUPPLY: next_read = {30'h00000000, supply_select};
            ADDR_CODEWORD: next_read = code_word;
            ADDR_IRQ_STATUS: next_read = 32'(irq_status);
            ADDR_IRQ_MASK: next_read = 32'(irq_mask);
            ADDR_STATUS: next_read = status_word(ctrl[0][COMPAT_BIT]);
            ADDR_STORED0: next_read = 32'(stored[0]);
            ADDR_STORED1: next_read = 32'(stored[1]);
            default: next_read = '0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset)
            read_data <= '0;
        else if (read_strobe)
            read_data <= next_read;
        else
            read_data <= '0;
    end

    // checks next to the logic
    a_supply_guard: assert property (
        @(posedge clock) disable iff (reset)
        (write_supply && code_word != CODE_WORD_USER) |=>
        $stable(supply_select))
        else $error("supply changed without code word");

    a_supply_pass: assert property (
        @(posedge clock) disable iff (reset)
        (write_supply && code_word == CODE_WORD_USER &&
         write_data[1:0] <= SUPPLY_24V) |=>
        supply_select == $past(write_data[1:0]))
        else $error("supply write with code word not taken");

    a_supply_reset: assert property (
        @(posedge clock) reset |=> supply_select == SUPPLY_5V)
        else $error("supply not 5 V after reset");

    a_eval_reset: assert property (
        @(posedge clock) reset |=> ctrl[0][EVAL_LSB +: 2] == EVAL_X4)
        else $error("evaluation not 4-fold after reset");

    a_count_read: assert property (
        @(posedge clock) disable iff (reset)
        (read_strobe && address == ADDR_COUNT0) |=>
        read_data == 32'($past(count[0])))
        else $error("count read mismatch");

    a_read_idle: assert property (
        @(posedge clock) disable iff (reset)
        !read_strobe |=> read_data == '0)
        else $error("read data not zero outside a read");

    a_set_host: assert property (
        @(posedge clock) disable iff (reset)
        set_req[0] |=> count[0] == $past(set_value[COUNT_WIDTH-1:0]))
        else $error("host set not applied");

    a_clear_count: assert property (
        @(posedge clock) disable iff (reset)
        (!set_req[0] && (ctrl[0][CLEAR_BIT] ||
         (ctrl[0][COMPAT_BIT] && g_chan[0].latch_rise))) |=>
        count[0] == '0)
        else $error("count not reset");

    a_latch_store: assert property (
        @(posedge clock) disable iff (reset)
        g_chan[0].latch_rise |=> stored[0] == $past(count[0]))
        else $error("latch did not store count");

    a_latch_seen: assert property (
        @(posedge clock) disable iff (reset)
        g_chan[0].latch_rise |=> latch_seen[0])
        else $error("latch status not set");

    a_gate_freeze: assert property (
        @(posedge clock) disable iff (reset)
        (ctrl[0][COMPAT_BIT] && gate_in[0] && !set_req[0] &&
         !ctrl[0][CLEAR_BIT] && !(latch_in[0] && !latch_prev[0]))
        |=> $stable(count[0]))
        else $error("gate did not freeze count");

    a_step_up: assert property (
        @(posedge clock) disable iff (reset)
        (step[0] && !step_down[0] && !set_req[0] && !ctrl[0][CLEAR_BIT]
         && !g_chan[0].frozen && !(latch_in[0] && !latch_prev[0]))
        |=> count[0] == $past(count[0]) + 1'b1)
        else $error("forward step not counted");

    a_step_down: assert property (
        @(posedge clock) disable iff (reset)
        (step[0] && step_down[0] && !set_req[0] && !ctrl[0][CLEAR_BIT]
         && !g_chan[0].frozen && !g_chan[0].latch_rise)
        |=> count[0] == $past(count[0]) - 1'b1)
        else $error("backward step not counted");

    a_sync_delay: assert property (
        @(posedge clock) disable iff (reset)
        (!$past(reset) && !$past(reset, 2)) |->
        a_sync == $past(track_a, 2))
        else $error("track A not two flops behind the pin");

    a_toggle_fresh: assert property (
        @(posedge clock) disable iff (reset)
        (step[0] && !g_chan[0].frozen) |=>
        data_toggle != $past(data_toggle))
        else $error("fresh data toggle did not flip");

    a_wrap_sticky: assert property (
        @(posedge clock) disable iff (reset)
        wrap[0] |=> irq_status[IRQ_WRAP0])
        else $error("wrap event not recorded");

    a_irq_level: assert property (
        @(posedge clock) disable iff (reset)
        (|(irq_status & irq_mask)) |=> irq)
        else $error("interrupt not raised");
endmodule : quad_counter
`default_nettype wire

// >>> verif/encoder_model.sv
// encoder and pulse generator model driving tracks A and B
`timescale 1ns/1ns
`default_nettype none
module encoder_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic go,
    input wire logic up,
    input wire logic pulse,
    output logic a,
    output logic b
);
    logic [1:0] wait_cnt;
    // one step per go; pulse mode settles B well before the A edge
    always_ff @(posedge clock) begin
        if (reset) begin
            a <= 1'b0;
            b <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (go && pulse) begin
            b <= ~up;
            wait_cnt <= 2'h3;
        end else if (go) begin
            if (up == (a == b)) a <= ~a;
            else b <= ~b;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
            if (wait_cnt == 2'h1) a <= ~a;
        end
    end
endmodule : encoder_model
`default_nettype wire

// >>> verif/tb_quad_counter.sv
// self-checking bench for the two-channel quadrature counter
`timescale 1ns/1ns
`default_nettype none
module tb_quad_counter
    import quad_pkg::*;
;
    logic clock, reset, write_strobe, read_strobe, irq;
    logic [1:0] track_a, track_b, latch_in, gate_in, set_req;
    logic [1:0] go, up, pulse, compat, prev_a, prev_b, supply_select;
    logic [7:0] address;
    logic [31:0] write_data, read_data, rnd, got;
    logic [31:0] exp_cnt [2];
    int sig [2];
    int ev [2];
    int err_count, total_checks;

    quad_counter quad_counter_i (.clock(clock), .reset(reset),
        .track_a(track_a), .track_b(track_b), .latch_in(latch_in),
        .gate_in(gate_in), .set_req(set_req), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data),
        .supply_select(supply_select), .irq(irq));
    encoder_model encoder_model_i [1:0] (.clock(clock), .reset(reset),
        .go(go), .up(up), .pulse(pulse), .a(track_a), .b(track_b));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // count step for one wire change; e 0 is 1-fold, 2 is 4-fold
    function automatic logic [31:0] delta(input logic pa, pb, na, nb,
                                          input int s, e);
        if (na != pa) begin
            if (e == 0 && !na) return 32'h0;
            if (s % 2 == 1) return nb ? 32'hFFFFFFFF : 32'h1;
            return (na != nb) ? 32'h1 : 32'hFFFFFFFF;
        end
        if (nb != pb && e == 2 && s % 2 == 0)
            return (nb == na) ? 32'h1 : 32'hFFFFFFFF;
        return 32'h0;
    endfunction : delta

    // reference count from the track wires; gate freezes only in compat
    always @(posedge clock) begin
        if (!reset) begin
            for (int c = 0; c < 2; c++) begin
                if (!(compat[c] && gate_in[c]))
                    exp_cnt[c] = exp_cnt[c] + delta(prev_a[c], prev_b[c],
                        track_a[c], track_b[c], sig[c], ev[c]);
            end
        end
        prev_a = track_a;
        prev_b = track_b;
    end

    task automatic check(input string name, input logic [31:0] seen, e);
        total_checks++;
        if (seen !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, e, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] e, m);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        check(n, read_data & m, e & m);
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    task automatic set_mode(input int c, s, e, input logic cp);
        sig[c] = s;
        ev[c] = e;
        compat[c] = cp;
        pulse[c] <= 1'(s % 2);
        wr(c ? ADDR_CTRL1 : ADDR_CTRL0, 32'(s) | (32'(e) << EVAL_LSB) |
           (32'(cp) << COMPAT_BIT));
    endtask : set_mode

    // dir 0 down, 1 up, 2 random; spacing covers sync and pulse setup
    task automatic steps(input int c, n, dir);
        for (int i = 0; i < n; i++) begin
            rnd = xs(rnd);
            @(posedge clock);
            up[c] <= (dir == 2) ? rnd[0] : dir[0];
            go[c] <= 1'b1;
            @(posedge clock);
            go[c] <= 1'b0;
            repeat (8) @(posedge clock);
        end
    endtask : steps

    task automatic pulse_in(input int which);
        @(posedge clock);
        if (which == 0) set_req[0] <= 1'b1;
        else latch_in[0] <= 1'b1;
        @(posedge clock);
        set_req <= 2'h0;
        repeat (4) @(posedge clock);
        latch_in <= 2'h0;
        settle();
    endtask : pulse_in

    initial begin
        #400000;
        err_count++;
        finish_test();
    end

    initial begin
        {write_strobe, read_strobe, latch_in, gate_in, set_req} = '0;
        {go, up, pulse, compat, prev_a, prev_b} = '0;
        address = 8'h00;
        write_data = 32'h0;
        rnd = 32'd93493;
        exp_cnt = '{32'h0, 32'h0};
        sig = '{0, 0};
        ev = '{2, 2};
        reset = 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd("ctrl0", ADDR_CTRL0, {26'h0, EVAL_X4, 4'h0}, '1);
        rd("ctrl1", ADDR_CTRL1, {26'h0, EVAL_X4, 4'h0}, '1);
        rd("count1", ADDR_COUNT1, 32'h0, '1);
        check("supply", 30'h0 + supply_select, 32'(SUPPLY_5V));
        check("irq", 31'h0 + irq, 32'h0);
        rd("toggle0", ADDR_STATUS, 32'h0, 32'h00018000);
        $display("reset test done");
        // every selector with every evaluation, settings kept across
        for (int s = 0; s < 6; s++) begin
            for (int e = 0; e < 3; e++) begin
                set_mode(0, s, e, 1'b0);
                set_mode(1, 5 - s, 2 - e, 1'b0);
                steps(0, 2 + int'(rnd[2:0]), 2);
                steps(1, 2 + int'(rnd[3:1]), 2);
                rd("count0", ADDR_COUNT0, exp_cnt[0], '1);
                rd("count1", ADDR_COUNT1, exp_cnt[1], '1);
            end
        end
        $display("mode test done");
        // load top count, wrap upwards, interrupt raised and cleared
        wr(ADDR_IRQ_STATUS, 32'h7);
        set_mode(0, 0, 2, 1'b0);
        wr(ADDR_STATUS, 32'hFFFFFFFF);
        pulse_in(0);
        exp_cnt[0] = 32'hFFFFFFFF;
        rd("set", ADDR_COUNT0, exp_cnt[0], '1);
        wr(ADDR_IRQ_MASK, 32'h1);
        steps(0, 1, 1);
        rd("wrap", ADDR_COUNT0, exp_cnt[0], '1);
        rd("wrap_bit", ADDR_IRQ_STATUS, 32'h1, 32'h1);
        check("irq_wrap", 31'h0 + irq, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        settle();
        check("irq_clear", 31'h0 + irq, 32'h0);
        $display("wrap test done");
        // supply writes only behind the code word, one setting for both
        wr(ADDR_IRQ_MASK, 32'h4);
        wr(ADDR_SUPPLY, 32'h2);
        settle();
        check("locked", 30'h0 + supply_select, 32'h0);
        check("irq_rej", 31'h0 + irq, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h4);
        wr(ADDR_CODEWORD, CODE_WORD_USER);
        for (int v = 1; v < 4; v++) begin
            wr(ADDR_SUPPLY, 32'(v));
            settle();
            check("supply", 30'h0 + supply_select, v > 2 ? 2 : v);
        end
        wr(ADDR_CODEWORD, 32'h0);
        wr(ADDR_SUPPLY, 32'h1);
        rd("supply_reg", ADDR_SUPPLY, 32'h2, 32'h3);
        $display("supply test done");
        // gate ignored and latch only stores outside compat mode
        gate_in[0] <= 1'b1;
        steps(0, 4, 2);
        gate_in[0] <= 1'b0;
        pulse_in(1);
        rd("latch", ADDR_STATUS, 32'h00100001, 32'h00100001);
        rd("latch_rd", ADDR_STATUS, 32'h0, 32'h1);
        rd("kept", ADDR_COUNT0, exp_cnt[0], '1);
        rd("stored", ADDR_STORED0, exp_cnt[0], '1);
        // compat: latch resets, gate freezes, host set still loads
        set_mode(0, 0, 2, 1'b1);
        pulse_in(1);
        exp_cnt[0] = 32'h0;
        rd("compat_rst", ADDR_COUNT0, exp_cnt[0], '1);
        rd("compat_bit", ADDR_STATUS, 32'h2001, 32'h2001);
        gate_in[0] <= 1'b1;
        settle();
        steps(0, 4, 2);
        gate_in[0] <= 1'b0;
        rd("frozen", ADDR_COUNT0, exp_cnt[0], '1);
        rnd = xs(rnd);
        wr(ADDR_STATUS, rnd);
        pulse_in(0);
        exp_cnt[0] = rnd;
        rd("compat_set", ADDR_COUNT0, exp_cnt[0], '1);
        // clear bit with compat kept: count to zero, bit drops again
        wr(ADDR_CTRL0, 32'h00000320);
        exp_cnt[0] = 32'h0;
        rd("clear", ADDR_COUNT0, exp_cnt[0], '1);
        rd("clear_bit", ADDR_CTRL0, 32'h00000120, '1);
        wr(8'h24, 32'hFFFFFFFF);
        rd("unmapped", 8'h24, 32'h0, '1);
        $display("latch test done");
        finish_test();
    end
endmodule : tb_quad_counter
`default_nettype wire
